// *** rtl/mia_pkg.sv ***
// constants, field layout and types of the maskable interrupt acceptance block
//
// Summary of operation
// RULE1: global enable gates all sources; resets to 0; code gates peripheral sources only, special and software requests pass
// RULE2: hardware sets pending; cleared after acceptance
// RULE3: software clears pending by writing 0 only
// RULE4: three-bit source priority, 000 means disabled
// RULE5: accept when enable, pending, level above CPU level
// RULE6: CPU level n admits n+1 up; 7 blocks
// RULE7: enable, pending, priority, CPU level stored independently
// RULE8: software disables interrupts before changing control
// RULE9: software pads control write before re-enabling
// RULE10: software uses read-modify-write bit instructions
// RULE11: software clears pending with plain move
// RULE12: evaluate at instruction end, sequence next cycle
// RULE13: string instructions are suspended for the sequence
// RULE14: information fetch clears winning source's pending bit
// RULE15: save flags, then clear enable, debug, stack-select; code keeps stack-select for software numbers 32 up
// RULE16: push flags and PC, then load CPU level
// RULE17: wait before sequence at most thirty cycles
// RULE18: sequence 18/19/20 cycles by alignment and bus
// RULE19: debugger adds two, step or match adds one
// RULE20: watchdog and NMI load 7, others unchanged
// RULE21: software places vectors at even addresses
// RULE22: enable and level in flags; pending in control
// RULE23: equal levels resolved by fixed hardware order
// RULE24: only the single winner is reported and cleared
package mia_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses, low 12 address bits decoded)
    localparam logic [11:0] FLAGS_OFS     = 12'h000;
    localparam logic [11:0] INFO_OFS      = 12'h004;
    localparam logic [11:0] STAT_OFS      = 12'h008;
    localparam logic [11:0] CTRL_BASE     = 12'h040;

    // field positions
    localparam int          FLG_I_BIT     = 0;
    localparam int          FLG_D_BIT     = 1;
    localparam int          FLG_U_BIT     = 2;
    localparam int          FLG_IPL_LSB   = 12;
    localparam int          CTRL_REQ_BIT  = 3;
    localparam int          STAT_NUM_LSB  = 8;
    localparam int          STAT_LVL_LSB  = 16;
    localparam int          INFO_LVL_LSB  = 8;

    // values after reset
    localparam logic        IFLAG_RST     = 1'b0;
    localparam logic [2:0]  IPL_RST       = 3'h0;
    localparam logic [2:0]  PRIO_RST      = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // sequence timing in cycles
    localparam logic [4:0]  SEQ_CYC_16    = 5'h12;
    localparam logic [4:0]  SEQ_CYC_8     = 5'h14;
    localparam logic [4:0]  SEQ_DBC_ADD   = 5'h02;
    localparam logic [4:0]  SEQ_STEP_ADD  = 5'h01;
    localparam int          MAX_WAIT_CYC  = 30;

    // levels and numbers
    localparam logic [2:0]  IPL_WDT_NMI   = 3'h7;
    localparam logic [5:0]  SW_KEEP_U_MIN = 6'h20;
    localparam logic [5:0]  PERIPH_NUM0   = 6'h04;
    localparam int          NUM_SRC_DEF   = 8;

    // special request slots
    localparam int          SP_NMI        = 0;
    localparam int          SP_DBC        = 1;
    localparam int          SP_WDT        = 2;
    localparam int          SP_STEP       = 3;
    localparam int          SP_MATCH      = 4;
    localparam int          SP_W          = 5;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_NMI,
        KIND_DBC,
        KIND_WDT,
        KIND_PERIPH,
        KIND_STEP,
        KIND_MATCH,
        KIND_SW
    } mia_kind_e;

endpackage

// *** rtl/mia_res_if.sv ***
// request and winner signals between the acceptance core and the resolver
interface mia_res_if #(
    parameter int N = 8
);
    logic [N-1:0]         pend;
    logic [N-1:0][2:0]    prio;
    logic                 iflag;
    logic [2:0]           cpu_priority_level;
    logic                 valid;
    logic [$clog2(N)-1:0] idx;
    logic [2:0]           lvl;

    modport core (
        output pend,
        output prio,
        output iflag,
        output cpu_priority_level,
        input  valid,
        input  idx,
        input  lvl
    );

    modport resolver (
        input  pend,
        input  prio,
        input  iflag,
        input  cpu_priority_level,
        output valid,
        output idx,
        output lvl
    );
endinterface

// *** rtl/mia_resolver.sv ***
// picks the single eligible maskable source of highest level
module mia_resolver #(
    parameter int N = 8
) (
    mia_res_if.resolver res
);
    import mia_pkg::*;

    logic [N-1:0] elig;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_elig
            assign elig[g] = res.iflag & res.pend[g] & (res.prio[g] > res.cpu_priority_level); // RULE5
        end
    endgenerate

    // scan downward with >= so that on equal levels the lower index wins
    always_comb begin
        res.valid = 1'b0;
        res.idx   = '0;
        res.lvl   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (elig[i] && res.prio[i] >= res.lvl) begin // RULE23
                res.valid = 1'b1;
                res.idx   = ($clog2(N))'(i);
                res.lvl   = res.prio[i];
            end
        end
    end

endmodule

// *** rtl/mia_core.sv ***
// maskable interrupt acceptance and interrupt sequence timing, AHB-Lite registers
module mia_core
    import mia_pkg::*;
#(
    parameter int N = NUM_SRC_DEF
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // ahb-lite slave
    input  wire logic              hsel_i,
    input  wire logic [31:0]       haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic [31:0]       hwdata_i,
    input  wire logic              hready_i,
    output logic      [31:0]       hrdata_o,
    output logic                   hreadyout_o,
    output logic                   hresp_o,
    // request sources
    input  wire logic [N-1:0]      irq_req_i,
    input  wire logic              nmi_req_i,
    input  wire logic              dbc_req_i,
    input  wire logic              wdt_req_i,
    input  wire logic              step_req_i,
    input  wire logic              match_req_i,
    // cpu core status
    input  wire logic              instr_done_i,
    input  wire logic              string_active_i,
    input  wire logic              sw_int_i,
    input  wire logic [5:0]        sw_num_i,
    input  wire logic              bus8_i,
    input  wire logic              vec_odd_i,
    input  wire logic              sp_odd_i,
    // sequence outputs
    output logic                   seq_start_o,
    output logic                   seq_active_o,
    output logic                   seq_done_o,
    output mia_pkg::mia_kind_e     int_kind_o,
    output logic      [5:0]        int_num_o,
    output logic      [2:0]        int_level_o,
    output logic      [15:0]       saved_flags_o,
    output logic                   iflag_o,
    output logic      [2:0]        ipl_o
);
    import mia_pkg::*;

    typedef enum logic {
        ST_IDLE,
        ST_SEQ
    } mia_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic                  dflag,       next_dflag;
    logic                  uflag,       next_uflag;
    logic                  next_iflag;
    logic [2:0]            next_ipl;
    logic [N-1:0][2:0]     prio,        next_prio;
    logic [N-1:0]          pend,        next_pend;
    logic [SP_W-1:0]       spec,        next_spec;
    logic                  ph_wr,       next_ph_wr;
    logic [11:0]           ph_addr,     next_ph_addr;
    logic [31:0]           next_hrdata;
    mia_state_e            state,       next_state;
    logic [4:0]            cnt,         next_cnt;
    logic                  next_start,  next_active, next_done;
    mia_kind_e             next_kind;
    logic [5:0]            next_num;
    logic [2:0]            next_lvl;
    logic [15:0]           next_saved;

    // combinational helpers
    logic [15:0]           flags_word;
    mia_kind_e             sel_kind;
    logic [5:0]            sel_num;
    logic [2:0]            sel_lvl;
    logic [4:0]            seq_len;
    logic                  accept;
    logic                  seq_end;
    logic                  info_rd;
    logic [31:0]           rd;

    mia_res_if #(.N(N)) res ();

    mia_resolver #(.N(N)) u_res (
        .res (res)
    );

    assign res.pend  = pend;
    assign res.prio  = prio;
    assign res.iflag = iflag_o;
    assign res.cpu_priority_level   = ipl_o;

    always_comb begin
        flags_word                            = '0;
        flags_word[FLG_I_BIT]                 = iflag_o; // RULE22
        flags_word[FLG_D_BIT]                 = dflag;
        flags_word[FLG_U_BIT]                 = uflag;
        flags_word[FLG_IPL_LSB +: 3]          = ipl_o;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // selection among all request kinds in fixed hardware order
    always_comb begin
        sel_kind = KIND_NONE;
        sel_num  = '0;
        sel_lvl  = '0;
        if (spec[SP_NMI]) begin
            sel_kind = KIND_NMI;
            sel_lvl  = IPL_WDT_NMI; // RULE20
        end else if (spec[SP_DBC]) begin
            sel_kind = KIND_DBC;
        end else if (spec[SP_WDT]) begin
            sel_kind = KIND_WDT;
            sel_lvl  = IPL_WDT_NMI; // RULE20
        end else if (res.valid) begin
            sel_kind = KIND_PERIPH; // RULE24
            sel_num  = PERIPH_NUM0 + 6'(res.idx);
            sel_lvl  = res.lvl;
        end else if (spec[SP_STEP]) begin
            sel_kind = KIND_STEP;
        end else if (spec[SP_MATCH]) begin
            sel_kind = KIND_MATCH;
        end else if (instr_done_i && sw_int_i) begin
            sel_kind = KIND_SW;
            sel_num  = sw_num_i;
        end
    end

    // sequence length for the request about to be accepted
    always_comb begin
        if (bus8_i) begin
            seq_len = SEQ_CYC_8; // RULE18
        end else begin
            seq_len = SEQ_CYC_16 + {4'h0, vec_odd_i} + {4'h0, sp_odd_i}; // RULE18
        end
        if (sel_kind == KIND_DBC) begin
            seq_len = seq_len + SEQ_DBC_ADD; // RULE19
        end else if (sel_kind == KIND_STEP || sel_kind == KIND_MATCH) begin
            seq_len = seq_len + SEQ_STEP_ADD; // RULE19
        end
    end

    // sampled only at instruction end, or mid-way through a suspendable string
    // instruction; the core bounds that wait, this block does not time it
    assign accept  = (state == ST_IDLE) && (instr_done_i || string_active_i)
                     && (sel_kind != KIND_NONE); // RULE12 RULE13 RULE17
    assign seq_end = (state == ST_SEQ) && (cnt == 5'h00);

    ////////////////////////////////////////////////////////////////////////////////
    // register file and bus
    always_comb begin
        next_iflag   = iflag_o;
        next_dflag   = dflag;
        next_uflag   = uflag;
        next_ipl     = ipl_o;
        next_prio    = prio;
        next_pend    = pend;
        next_spec    = spec;
        next_hrdata  = hrdata_o;
        next_ph_wr   = 1'b0;
        next_ph_addr = ph_addr;
        info_rd      = 1'b0;
        rd           = '0;
        // address phase: reads are answered from the registers at this edge
        if (hsel_i && htrans_i[1] && hready_i) begin
            next_ph_wr   = hwrite_i;
            next_ph_addr = haddr_i[11:0];
            if (haddr_i[11:0] == FLAGS_OFS) begin
                rd[15:0] = flags_word;
            end else if (haddr_i[11:0] == INFO_OFS) begin
                rd[5:0]                  = PERIPH_NUM0 + 6'(res.idx);
                rd[INFO_LVL_LSB +: 3]    = res.lvl;
                info_rd                  = !hwrite_i;
            end else if (haddr_i[11:0] == STAT_OFS) begin
                rd[0]                    = seq_active_o;
                rd[STAT_NUM_LSB +: 6]    = int_num_o;
                rd[STAT_LVL_LSB +: 3]    = int_level_o;
            end
            for (int i = 0; i < N; i++) begin
                if (haddr_i[11:0] == CTRL_BASE + 12'(4 * i)) begin
                    rd[2:0]          = prio[i]; // RULE4
                    rd[CTRL_REQ_BIT] = pend[i];
                end
            end
            if (!hwrite_i) begin
                next_hrdata = rd;
            end
        end
        // data phase write; each field only touches its own storage
        if (ph_wr) begin
            if (ph_addr == FLAGS_OFS) begin
                next_iflag = hwdata_i[FLG_I_BIT]; // RULE1 RULE7
                next_dflag = hwdata_i[FLG_D_BIT];
                next_uflag = hwdata_i[FLG_U_BIT];
                next_ipl   = hwdata_i[FLG_IPL_LSB +: 3]; // RULE6
            end
            for (int i = 0; i < N; i++) begin
                if (ph_addr == CTRL_BASE + 12'(4 * i)) begin
                    next_prio[i] = hwdata_i[2:0]; // RULE4 RULE7
                    if (!hwdata_i[CTRL_REQ_BIT]) begin
                        next_pend[i] = 1'b0; // RULE3
                    end
                end
            end
        end
        // sequence side effects
        if (accept) begin
            next_iflag = 1'b0; // RULE15
            next_dflag = 1'b0; // RULE15
            if (!(sel_kind == KIND_SW && sw_num_i >= SW_KEEP_U_MIN)) begin
                next_uflag = 1'b0; // RULE15
            end
            unique case (sel_kind)
                KIND_NMI:    next_spec[SP_NMI]   = 1'b0;
                KIND_DBC:    next_spec[SP_DBC]   = 1'b0;
                KIND_WDT:    next_spec[SP_WDT]   = 1'b0;
                KIND_STEP:   next_spec[SP_STEP]  = 1'b0;
                KIND_MATCH:  next_spec[SP_MATCH] = 1'b0;
                KIND_PERIPH: next_pend[res.idx]  = 1'b0; // RULE2 RULE14 RULE24
                default:     next_spec           = next_spec;
            endcase
        end
        // reading the information word also clears the winner, as the fetch does
        if (info_rd && res.valid) begin
            next_pend[res.idx] = 1'b0; // RULE14
        end
        if (seq_end && (int_kind_o == KIND_PERIPH || int_kind_o == KIND_NMI
                        || int_kind_o == KIND_WDT)) begin
            next_ipl = int_level_o; // RULE16 RULE20
        end
        // a new request wins over any clear in the same cycle
        next_pend = next_pend | irq_req_i; // RULE2
        next_spec = next_spec | {match_req_i, step_req_i, wdt_req_i, dbc_req_i, nmi_req_i};
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            iflag_o     <= IFLAG_RST; // RULE1
            dflag       <= 1'b0;
            uflag       <= 1'b0;
            ipl_o       <= IPL_RST;
            prio        <= {N{PRIO_RST}};
            pend        <= '0;
            spec        <= '0;
            ph_wr       <= 1'b0;
            ph_addr     <= 12'h000;
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            iflag_o     <= next_iflag;
            dflag       <= next_dflag;
            uflag       <= next_uflag;
            ipl_o       <= next_ipl;
            prio        <= next_prio;
            pend        <= next_pend;
            spec        <= next_spec;
            ph_wr       <= next_ph_wr;
            ph_addr     <= next_ph_addr;
            hrdata_o    <= next_hrdata;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt sequence
    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_start  = 1'b0;
        next_done   = 1'b0;
        next_active = seq_active_o;
        next_kind   = int_kind_o;
        next_num    = int_num_o;
        next_lvl    = int_level_o;
        next_saved  = saved_flags_o;
        unique case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state  = ST_SEQ; // RULE12
                    next_cnt    = seq_len - 5'h01; // RULE18
                    next_start  = 1'b1;
                    next_active = 1'b1;
                    next_kind   = sel_kind;
                    next_num    = sel_num;
                    next_lvl    = sel_lvl;
                    next_saved  = flags_word; // RULE15 RULE16
                end
            end
            ST_SEQ: begin
                if (cnt == 5'h00) begin
                    next_state  = ST_IDLE;
                    next_active = 1'b0;
                    next_done   = 1'b1; // RULE16
                end else begin
                    next_cnt    = cnt - 5'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state         <= ST_IDLE;
            cnt           <= 5'h00;
            seq_start_o   <= 1'b0;
            seq_active_o  <= 1'b0;
            seq_done_o    <= 1'b0;
            int_kind_o    <= KIND_NONE;
            int_num_o     <= 6'h00;
            int_level_o   <= 3'h0;
            saved_flags_o <= 16'h0000;
        end else begin
            state         <= next_state;
            cnt           <= next_cnt;
            seq_start_o   <= next_start;
            seq_active_o  <= next_active;
            seq_done_o    <= next_done;
            int_kind_o    <= next_kind;
            int_num_o     <= next_num;
            int_level_o   <= next_lvl;
            saved_flags_o <= next_saved;
        end
    end

endmodule

// *** tb/mia_cpu_model.sv ***
// cpu core model: instruction ends and string windows
module mia_cpu_model (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // bench control, block status
    input  wire logic run_i,
    input  wire logic str_i,
    input  wire logic seq_active_i,
    // core status to the block
    output logic      instr_done_o,
    output logic      string_active_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    // core is frozen while the sequence owns the bus
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase <= 2'h0;
        end else begin
            phase <= seq_active_i ? 2'h0 : phase + 2'h1;
        end
    end
    // four-cycle instructions, far under the thirty-cycle wait
    assign instr_done_o = run_i && !seq_active_i && phase == 2'h3;
    assign string_active_o = str_i && !seq_active_i;
endmodule

// *** tb/mia_chk.sv ***
// port assertions of the interrupt acceptance block
module mia_chk
    import mia_pkg::*;
#(
    parameter int N = 8
) (
    // clock and reset
    input wire logic               clk_i,
    input wire logic               resetn_i,
    // core status
    input wire logic               bus8_i,
    input wire logic               vec_odd_i,
    input wire logic               sp_odd_i,
    input wire logic               instr_done_i,
    input wire logic               string_active_i,
    // sequence outputs
    input wire logic               seq_start_o,
    input wire logic               seq_active_o,
    input wire logic               seq_done_o,
    input wire mia_pkg::mia_kind_e int_kind_o,
    input wire logic [5:0]         int_num_o,
    input wire logic [2:0]         int_level_o,
    input wire logic               iflag_o,
    input wire logic [2:0]         ipl_o
);
    logic       b8_q;
    logic       vo_q;
    logic       so_q;
    logic [4:0] cnt;
    logic [4:0] exp_q;
    logic [4:0] exp_now;
    // length follows the inputs sampled at the accepting edge
    always_comb begin
        exp_now = b8_q ? 5'h14 : 5'h12 + 5'(vo_q) + 5'(so_q);
        if (int_kind_o == KIND_DBC) begin
            exp_now = exp_now + 5'h2;
        end else if (int_kind_o == KIND_STEP || int_kind_o == KIND_MATCH) begin
            exp_now = exp_now + 5'h1;
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {b8_q, vo_q, so_q, cnt, exp_q} <= '0;
        end else begin
            {b8_q, vo_q, so_q} <= {bus8_i, vec_odd_i, sp_odd_i};
            cnt <= seq_start_o ? 5'h1 : cnt + 5'(seq_active_o);
            exp_q <= seq_start_o ? exp_now : exp_q;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////////////////////////
    iflag_reset_a: assert property (@(posedge clk_i) disable iff (1'b0)
        !resetn_i |-> !iflag_o && ipl_o == 3'h0) else $error("enable not clear in reset");
    start_cause_a: assert property (seq_start_o |->
        $past(instr_done_i) || $past(string_active_i)) else $error("start without boundary");
    start_clear_a: assert property (seq_start_o |->
        seq_active_o && !iflag_o) else $error("enable not cleared at start");
    accept_cond_a: assert property (seq_start_o && int_kind_o == KIND_PERIPH |->
        $past(iflag_o) && int_level_o > $past(ipl_o) && int_num_o < PERIPH_NUM0 + N)
        else $error("peripheral accepted against gate");
    seq_len_a: assert property ($fell(seq_active_o) |->
        cnt == exp_q) else $error("sequence length wrong");
    done_pulse_a: assert property ($fell(seq_active_o) |->
        seq_done_o ##1 !seq_done_o) else $error("done not one pulse");
    ipl_load_a: assert property (seq_done_o && int_kind_o == KIND_PERIPH |->
        ipl_o == int_level_o) else $error("level not loaded");
    ipl_fixed_a: assert property (seq_done_o && int_kind_o inside {KIND_NMI, KIND_WDT} |->
        ipl_o == 3'h7 && int_level_o == 3'h7) else $error("level not seven");
    ipl_keep_a: assert property (seq_done_o &&
        int_kind_o inside {KIND_DBC, KIND_STEP, KIND_MATCH} |-> ipl_o == $past(ipl_o))
        else $error("level changed");
endmodule

// *** tb/tb.sv ***
// self-checking bench of the interrupt acceptance block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mia_pkg::*;
    localparam int N = 8;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, run = 1'b0, str = 1'b0, sw = 1'b0, got;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic hready, hresp, sstart, sact, sdone, iflag, idone, strx;
    logic [N-1:0] irq = '0;
    logic [4:0] spc = '0;
    logic bus8 = 1'b0, vodd = 1'b0, sodd = 1'b0;
    mia_kind_e kind;
    mia_kind_e kinds[5] = '{KIND_NMI, KIND_DBC, KIND_WDT, KIND_STEP, KIND_MATCH};
    logic [5:0] num;
    logic [2:0] lvl, cpu_priority_level;
    logic [15:0] sflags;
    int err_count = 0;
    int checked = 0;
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    mia_core #(.N(N)) i_mia_core (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .irq_req_i(irq), .nmi_req_i(spc[SP_NMI]),
        .dbc_req_i(spc[SP_DBC]), .wdt_req_i(spc[SP_WDT]), .step_req_i(spc[SP_STEP]),
        .match_req_i(spc[SP_MATCH]), .instr_done_i(idone), .string_active_i(strx),
        .sw_int_i(sw), .sw_num_i(6'h28), .bus8_i(bus8), .vec_odd_i(vodd),
        .sp_odd_i(sodd), .seq_start_o(sstart), .seq_active_o(sact), .seq_done_o(sdone),
        .int_kind_o(kind), .int_num_o(num), .int_level_o(lvl), .saved_flags_o(sflags),
        .iflag_o(iflag), .ipl_o(cpu_priority_level));
    mia_cpu_model i_mia_cpu_model (.clk_i(clk_i), .resetn_i(resetn_i), .run_i(run),
        .str_i(str), .seq_active_i(sact), .instr_done_o(idone), .string_active_o(strx));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic hw;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (n >= 40) begin
            chk(0, 1, "bus hang");
            complete_run();
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        hw();
        htrans <= 2'h0;
        hwdata <= d;
        hw();
        r = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string m);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        chk(r, e, m);
        chk(hresp, 32'h0, "response");
    endtask
    function automatic logic [11:0] ca(input int i);
        return CTRL_BASE + 12'(4 * i);
    endfunction
    task automatic pulse(input logic [N-1:0] m, input logic [4:0] s);
        irq <= m;
        spc <= s;
        @(posedge clk_i);
        irq <= '0;
        spc <= '0;
    endtask
    task automatic sq(output logic g);
        g = 1'b0;
        for (int n = 0; n < 60 && g == 1'b0; n++) begin
            @(posedge clk_i);
            #1;
            g = (sdone === 1'b1);
        end
        @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        rd(FLAGS_OFS, 32'h0, "flags reset");
        rd(ca(0), 32'h0, "control reset");
        rd(12'h100, 32'h0, "unmapped read");
        wr(ca(1), 32'hf);
        rd(ca(1), 32'h7, "priority field");
        rd(FLAGS_OFS, 32'h0, "flags untouched");
        run <= 1'b1;
        wr(ca(2), 32'h3);
        wr(FLAGS_OFS, 32'h1);
        pulse(8'h04, 5'h0);
        sq(got);
        chk(got, 1, "no accept");
        chk(num, 6, "number");
        chk(lvl, 3, "level");
        chk(cpu_priority_level, 3, "level load");
        chk(iflag, 0, "enable clear");
        chk(sflags, 1, "saved flags");
        rd(ca(2), 32'h3, "pending after accept");
        wr(FLAGS_OFS, 32'h0);
        pulse(8'h04, 5'h0);
        sq(got);
        chk(got, 0, "masked accept");
        rd(ca(2), 32'hb, "pending held");
        wr(ca(2), 32'h3);
        rd(ca(2), 32'h3, "pending cleared");
        wr(ca(0), 32'h5);
        for (int n = 0; n < 8; n++) begin
            {bus8, vodd, sodd} <= 3'(n);
            wr(FLAGS_OFS, 32'h1 | (32'(n) << FLG_IPL_LSB));
            pulse(8'h01, 5'h0);
            sq(got);
            chk(got, 32'(n < 5), "level gate");
            if (got !== 1'b1) begin
                wr(ca(0), 32'h5);
            end
        end
        run <= 1'b0;
        wr(ca(1), 32'h4);
        wr(ca(3), 32'h4);
        wr(FLAGS_OFS, 32'h1);
        pulse(8'h0a, 5'h0);
        rd(INFO_OFS, 32'h405, "info winner");
        rd(ca(1), 32'h4, "winner cleared");
        rd(ca(3), 32'hc, "loser kept");
        str <= 1'b1;
        sq(got);
        chk(got, 1, "string accept");
        chk(num, 7, "second source");
        rd(STAT_OFS, 32'h40700, "status");
        str <= 1'b0;
        run <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            pulse(8'h0, 5'(1 << k));
            sq(got);
            chk(got, 1, "special accept");
            chk(kind, kinds[k], "special kind");
        end
        wr(FLAGS_OFS, 32'h4);
        sw <= 1'b1;
        sq(got);
        sw <= 1'b0;
        chk(kind, KIND_SW, "software kind");
        rd(FLAGS_OFS, 32'h4, "stack select kept");
        complete_run();
    end
endmodule
bind mia_core mia_chk #(.N(N)) i_mia_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .bus8_i(bus8_i), .vec_odd_i(vec_odd_i), .sp_odd_i(sp_odd_i),
    .instr_done_i(instr_done_i), .string_active_i(string_active_i),
    .seq_start_o(seq_start_o), .seq_active_o(seq_active_o), .seq_done_o(seq_done_o),
    .int_kind_o(int_kind_o), .int_num_o(int_num_o), .int_level_o(int_level_o),
    .iflag_o(iflag_o), .ipl_o(ipl_o));
